//--- pkg/seg_sync_if.sv
// carries segment sync between the link-side generator and the top
`timescale 1ns/1ps
interface seg_sync_if;
    logic       run;
    logic       pulse;
    modport gen (input run, output pulse);
    modport top (output run, input pulse);
endinterface : seg_sync_if

//--- pkg/sync_mgmt_pkg.sv
// constants and types shared by the port pin block
package sync_mgmt_pkg;
    localparam int unsigned     SEG_LEN          = 10;
    localparam logic [3:0]      SEG_LAST         = 4'h9;
    localparam logic [3:0]      SEG_FIRST        = 4'h0;
    localparam int unsigned     SYS_CLK_MHZ      = 100;
    localparam int unsigned     MGMT_CLK_DIV     = 20;
    localparam logic [4:0]      MGMT_HALF        = 5'(MGMT_CLK_DIV / 2 - 1);
    localparam logic [5:0]      MGMT_FRAME_BITS  = 6'h20;
    localparam logic [5:0]      MGMT_TA_BIT      = 6'h0e;
    localparam logic [5:0]      MGMT_BIT_LAST    = 6'h3f;
    localparam logic [31:0]     MGMT_PREAMBLE    = 32'hffff_ffff;
    localparam logic [1:0]      MGMT_START       = 2'h1;
    localparam logic [1:0]      MGMT_OP_WRITE    = 2'h1;
    localparam logic [1:0]      MGMT_OP_READ     = 2'h2;
    localparam logic [1:0]      MGMT_TA_WRITE    = 2'h2;

    typedef enum logic [1:0]
    {
        MODE_MII      = 2'h0,
        MODE_SERIAL   = 2'h1,
        MODE_SRC_SYNC = 2'h3
    } port_mode_t;

    typedef enum logic [1:0]
    {
        MG_IDLE  = 2'h0,
        MG_SHIFT = 2'h1,
        MG_DONE  = 2'h3
    } mgmt_state_t;
endpackage : sync_mgmt_pkg

//--- rtl/port_sync_mgmt.sv
// shared carrier-sense/segment-sync pin and station management pins of one port
// Behaviour
// - carrier sense may rise asynchronously, so it is synchronised before use.
// - in serial mode the shared pin pulses once per ten reference clocks.
// - in source-synchronous mode the pulse also comes once per ten reference clocks.
// - the shared pin is an input in MII mode and an output in either serial mode.
// - management write data is driven onto the bidirectional data pin.
// - management data is launched and sampled relative to the management clock.
// - the management clock pin is an input after reset until software makes it an output.
// - management frames follow the standard preamble, start, op, address, turnaround layout.
// - segment sync changes on the rising edge of the serial reference clock.
`timescale 1ns/1ps
module port_sync_mgmt
    import sync_mgmt_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        serial_ref_clock_in,
    input  wire logic        port_enable_in,
    input  wire port_mode_t  port_mode_in,
    input  wire logic        mgmt_clk_drive_in,
    input  wire logic        mgmt_start_in,
    input  wire logic        mgmt_read_in,
    input  wire logic [4:0]  mgmt_phy_addr_in,
    input  wire logic [4:0]  mgmt_reg_addr_in,
    input  wire logic [15:0] mgmt_wdata_in,
    input  wire logic        port_carrier_sense_in,
    output logic             port_carrier_sense_out,
    output logic             port_carrier_sense_oe_n_out,
    input  wire logic        mgmt_clock_pin_in,
    output logic             mgmt_clock_pin_out,
    output logic             mgmt_clock_pin_oe_n_out,
    input  wire logic        mgmt_data_pin_in,
    output logic             mgmt_data_pin_out,
    output logic             mgmt_data_pin_oe_n_out,
    output logic             carrier_sense_out,
    output logic             mgmt_busy_out,
    output logic             mgmt_done_out,
    output logic [15:0]      mgmt_rdata_out
);
    seg_sync_if sync_bus ();

    logic        serial_mode_q;
    logic [2:0]  crs_sync_q;
    logic        carrier_q;
    logic [4:0]  div_cnt_q;
    logic        mdc_int_q;
    logic [2:0]  mdc_ext_q;
    logic        mdc_hi_q;
    logic        mdc_rise;
    logic        mdc_fall;
    mgmt_state_t mg_state_q;
    logic [63:0] shift_q;
    logic [5:0]  bit_cnt_q;
    logic        op_read_q;
    logic [15:0] rdata_q;
    logic        done_q;
    logic        mdio_oe_n_q;
    logic        mdio_out_q;
    logic        crs_oe_n_q;
    logic        mdc_oe_n_q;
    logic [2:0]  mdio_in_q;
    logic        launched_q;
    logic        busy_q;

    function automatic logic is_serial(input port_mode_t m);
        return (m == MODE_SERIAL) || (m == MODE_SRC_SYNC);
    endfunction : is_serial

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            serial_mode_q <= 1'b0;
        else
            serial_mode_q <= port_enable_in && is_serial(port_mode_in);
    end

    assign sync_bus.run = serial_mode_q;

    seg_sync_gen u_seg_sync_gen
    (
        .link_clk_in (serial_ref_clock_in),
        .rst_in      (rst_in),
        .sync_bus    (sync_bus)
    );

    // pin direction; undriven until the port is enabled in a serial mode
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            crs_oe_n_q <= 1'b1;
        else
            crs_oe_n_q <= !(port_enable_in && is_serial(port_mode_in));
    end

    assign port_carrier_sense_oe_n_out = crs_oe_n_q;
    // output flop lives in the link domain so the pulse keeps its exact alignment
    assign port_carrier_sense_out      = sync_bus.pulse;

    // carrier sense input: rises async, so three stages and agreement of the last two
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            crs_sync_q <= 3'h0;
        else
            crs_sync_q <= {crs_sync_q[1:0], port_carrier_sense_in};
    end

    // the PHY keeps it high over busy media and collisions, so a plain level follows
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            carrier_q <= 1'b0;
        else if (!port_enable_in || serial_mode_q)
            carrier_q <= 1'b0;
        else if (crs_sync_q[1] == crs_sync_q[2])
            carrier_q <= crs_sync_q[2];
    end

    assign carrier_sense_out = carrier_q;

    // management clock: divided internally or taken from the pin
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mdc_oe_n_q <= 1'b1;
        else
            mdc_oe_n_q <= !mgmt_clk_drive_in;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_cnt_q <= 5'h0;
            mdc_int_q <= 1'b0;
        end
        else if (div_cnt_q == MGMT_HALF)
        begin
            div_cnt_q <= 5'h0;
            mdc_int_q <= !mdc_int_q;
        end
        else
            div_cnt_q <= div_cnt_q + 5'h1;
    end

    assign mgmt_clock_pin_out      = mdc_int_q;
    assign mgmt_clock_pin_oe_n_out = mdc_oe_n_q;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mdc_ext_q <= 3'h0;
            mdio_in_q <= 3'h0;
        end
        else
        begin
            mdc_ext_q <= {mdc_ext_q[1:0], mgmt_clock_pin_in};
            mdio_in_q <= {mdio_in_q[1:0], mgmt_data_pin_in};
        end
    end

    // filtered level of whichever management clock is in use
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mdc_hi_q <= 1'b0;
        else if (!mdc_oe_n_q)
            mdc_hi_q <= mdc_int_q;
        else if (mdc_ext_q[1] == mdc_ext_q[2])
            mdc_hi_q <= mdc_ext_q[2];
    end

    wire mdc_now = !mdc_oe_n_q ? mdc_int_q : ((mdc_ext_q[1] == mdc_ext_q[2]) ? mdc_ext_q[2] : mdc_hi_q);
    assign mdc_rise = mdc_now && !mdc_hi_q;
    assign mdc_fall = !mdc_now && mdc_hi_q;

    // management frame engine: launch on falling edge, sample on rising edge
    wire take = (mg_state_q == MG_IDLE) && mgmt_start_in && port_enable_in;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mg_state_q <= MG_IDLE;
        else
        begin
            case (mg_state_q)
                MG_IDLE:
                    if (take)
                        mg_state_q <= MG_SHIFT;
                MG_SHIFT:
                    if (mdc_rise && launched_q && bit_cnt_q == MGMT_BIT_LAST)
                        mg_state_q <= MG_DONE;
                MG_DONE:
                    mg_state_q <= MG_IDLE;
                default:
                    mg_state_q <= MG_IDLE;
            endcase
        end
    end

    // the divider runs free, so a rise can come before the first launch; it must not count
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            launched_q <= 1'b0;
        else if (mg_state_q != MG_SHIFT)
            launched_q <= 1'b0;
        else if (mdc_fall)
            launched_q <= 1'b1;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shift_q   <= 64'h0;
            op_read_q <= 1'b0;
        end
        else if (take)
        begin
            shift_q   <= {MGMT_PREAMBLE, MGMT_START,
                          mgmt_read_in ? MGMT_OP_READ : MGMT_OP_WRITE,
                          mgmt_phy_addr_in, mgmt_reg_addr_in, MGMT_TA_WRITE, mgmt_wdata_in};
            op_read_q <= mgmt_read_in;
        end
        else if (mg_state_q == MG_SHIFT && mdc_fall)
            shift_q <= {shift_q[62:0], 1'b0};
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mdio_out_q <= 1'b1;
        else if (mg_state_q == MG_SHIFT && mdc_fall)
            mdio_out_q <= shift_q[63];
    end

    // read frames release the pin at turnaround; idle and done leave it undriven
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mdio_oe_n_q <= 1'b1;
        else if (mg_state_q != MG_SHIFT)
            mdio_oe_n_q <= 1'b1;
        else if (mdc_fall)
            mdio_oe_n_q <= op_read_q && (bit_cnt_q >= (MGMT_FRAME_BITS + MGMT_TA_BIT));
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            bit_cnt_q <= 6'h0;
        else if (take)
            bit_cnt_q <= 6'h0;
        else if (mg_state_q == MG_SHIFT && mdc_rise && launched_q)
            bit_cnt_q <= bit_cnt_q + 6'h1;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_q <= 16'h0;
        else if (mg_state_q == MG_SHIFT && mdc_rise && launched_q && op_read_q
                 && bit_cnt_q > (MGMT_FRAME_BITS + MGMT_TA_BIT + 6'h1))
            rdata_q <= {rdata_q[14:0], mdio_in_q[2]};
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            done_q <= 1'b0;
        else
            done_q <= (mg_state_q == MG_DONE);
    end

    // busy has its own flop so the output carries no state decode
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            busy_q <= 1'b0;
        else if (take)
            busy_q <= 1'b1;
        else if (mg_state_q == MG_DONE)
            busy_q <= 1'b0;
    end

    assign mgmt_data_pin_out      = mdio_out_q;
    assign mgmt_data_pin_oe_n_out = mdio_oe_n_q;
    assign mgmt_busy_out          = busy_q;
    assign mgmt_done_out          = done_q;
    assign mgmt_rdata_out         = rdata_q;
endmodule : port_sync_mgmt

//--- rtl/seg_sync_gen.sv
// one-in-ten segment sync pulse generator on the serial link clock
`timescale 1ns/1ps
module seg_sync_gen
    import sync_mgmt_pkg::*;
(
    input  wire logic       link_clk_in,
    input  wire logic       rst_in,
    seg_sync_if.gen         sync_bus
);
    logic [2:0] run_sync_q;
    logic [3:0] seg_cnt_q;
    logic       pulse_q;

    // run comes from the system domain; three stages, second and third must both be high
    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
            run_sync_q <= 3'h0;
        else
            run_sync_q <= {run_sync_q[1:0], sync_bus.run};
    end

    wire run_ok = run_sync_q[1] & run_sync_q[2];

    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
            seg_cnt_q <= SEG_FIRST;
        else if (!run_ok || seg_cnt_q == SEG_LAST)
            seg_cnt_q <= SEG_FIRST;
        else
            seg_cnt_q <= seg_cnt_q + 4'h1;
    end

    // one cycle high on the first bit of each ten-bit segment, changes on rising edge
    always_ff @(posedge link_clk_in or posedge rst_in)
    begin
        if (rst_in)
            pulse_q <= 1'b0;
        else
            pulse_q <= run_ok && (seg_cnt_q == SEG_FIRST);
    end

    assign sync_bus.pulse = pulse_q;
endmodule : seg_sync_gen

//--- verification/phy_model.sv
// far-side phy: carrier sense and management read answers
`timescale 1ns/1ps
module phy_model
(
    input  wire logic mdc_in,
    input  wire logic mdio_rel_in,
    input  wire logic tx_busy_in,
    input  wire logic rx_busy_in,
    input  wire logic col_in,
    output logic      crs_out,
    output logic      mdio_en_out,
    output logic      mdio_out
);
    localparam logic [15:0] RD = 16'hc35a;
    logic [16:0] sr_q = 17'h00000;
    logic [4:0]  n_q  = 5'h12;
    assign crs_out = tx_busy_in | rx_busy_in | col_in;
    // first turnaround bit left to the pull-up, then a driven zero and data
    always @(negedge mdc_in)
        if (!mdio_rel_in)
        begin
            n_q <= 5'h00;
            sr_q <= {1'b0, RD};
        end
        else if (n_q != 5'h12)
        begin
            n_q <= n_q + 5'h01;
            sr_q <= (n_q != 5'h00) ? sr_q << 1 : sr_q;
        end
    assign mdio_en_out = n_q != 5'h00 && n_q != 5'h12;
    assign mdio_out = sr_q[16];
endmodule : phy_model

//--- verification/port_sync_mgmt_asserts.sv
// concurrent checks on the port pin block
`timescale 1ns/1ps
module port_sync_mgmt_asserts
    import sync_mgmt_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic       serial_ref_clock_in,
    input wire logic       port_enable_in,
    input wire port_mode_t port_mode_in,
    input wire logic       mgmt_clk_drive_in,
    input wire logic       mgmt_start_in,
    input wire logic       port_carrier_sense_in,
    input wire logic       port_carrier_sense_out,
    input wire logic       port_carrier_sense_oe_n_out,
    input wire logic       mgmt_clock_pin_out,
    input wire logic       mgmt_clock_pin_oe_n_out,
    input wire logic       mgmt_data_pin_out,
    input wire logic       mgmt_data_pin_oe_n_out,
    input wire logic       carrier_sense_out,
    input wire logic       mgmt_busy_out,
    input wire logic       mgmt_done_out
);
    localparam int LO = 1250;
    localparam int HI = 1300;
    logic [11:0] bcnt_q;
    // window is wide because the divider phase at start is free
    always_ff @(posedge clk_sys_in or posedge rst_in)
        if (rst_in)
            bcnt_q <= 12'h000;
        else
            bcnt_q <= mgmt_busy_out ? bcnt_q + 12'h001 : 12'h000;

    a_sync_one_wide: assert property (@(posedge serial_ref_clock_in) disable iff (rst_in)
        port_carrier_sense_out |=> !port_carrier_sense_out) else $error("sync pulse too wide");
    a_sync_period: assert property (@(posedge serial_ref_clock_in) disable iff (rst_in)
        $rose(port_carrier_sense_out) |=> !port_carrier_sense_out [*8] ##1 !port_carrier_sense_out
        ##1 (port_carrier_sense_out || !port_enable_in)) else $error("sync period not ten");
    a_sync_drives: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        port_enable_in && port_mode_in != MODE_MII |=> !port_carrier_sense_oe_n_out) else $error("sync pin undriven");
    a_crs_input: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (port_mode_in == MODE_MII) [*2] |-> port_carrier_sense_oe_n_out) else $error("sense pin driven");
    a_pins_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!port_enable_in && !mgmt_busy_out) [*2] |-> port_carrier_sense_oe_n_out && mgmt_data_pin_oe_n_out)
        else $error("pin driven while disabled");
    a_crs_synced: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(carrier_sense_out) |-> $past(port_carrier_sense_in, 3)) else $error("sense not synchronised");
    a_crs_gated: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (port_mode_in != MODE_MII) [*4] |-> !carrier_sense_out) else $error("sense seen in serial mode");
    a_mdc_input: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !mgmt_clk_drive_in [*2] |-> mgmt_clock_pin_oe_n_out) else $error("clock pin driven");
    a_mgmt_take: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mgmt_start_in && !mgmt_busy_out && port_enable_in |=> mgmt_busy_out) else $error("start not taken");
    a_frame_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mgmt_done_out |-> bcnt_q >= LO && bcnt_q <= HI ##1 !mgmt_busy_out) else $error("frame length wrong");
    a_mdio_launch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $changed(mgmt_data_pin_out) && !mgmt_data_pin_oe_n_out && mgmt_busy_out && !mgmt_done_out
        |-> !mgmt_clock_pin_out) else $error("data moved while clock high");
endmodule : port_sync_mgmt_asserts

bind port_sync_mgmt port_sync_mgmt_asserts i_chk (.*);

//--- verification/test_mii_serial_segment_sync_and_mgmt_pins.sv
// self-checking bench for the shared sync and management pins
`timescale 1ns/1ps
module test_mii_serial_segment_sync_and_mgmt_pins;
    import sync_mgmt_pkg::*;
    typedef struct packed {logic r; logic [4:0] pa; logic [4:0] ra; logic [15:0] wd; logic [15:0] rd;} row_t;
    localparam logic [15:0] RD = 16'hc35a;
    row_t rows [3] = '{'{1'b0, 5'h1f, 5'h00, 16'ha5c3, 16'h0000},
                      '{1'b1, 5'h00, 5'h1f, 16'h0000, RD},
                      '{1'b0, 5'h15, 5'h0a, 16'h0001, RD}};
    logic clk_sys_in = 1'b0, serial_ref_clock_in = 1'b0, rst_in = 1'b1, port_enable_in = 1'b0;
    logic mgmt_clk_drive_in = 1'b0, mgmt_start_in = 1'b0, mgmt_read_in = 1'b0;
    port_mode_t port_mode_in = MODE_MII;
    logic [4:0] mgmt_phy_addr_in = 5'h00, mgmt_reg_addr_in = 5'h00;
    logic [15:0] mgmt_wdata_in = 16'h0000, mgmt_rdata_out;
    logic port_carrier_sense_in, port_carrier_sense_out, port_carrier_sense_oe_n_out;
    logic mgmt_clock_pin_in, mgmt_clock_pin_out, mgmt_clock_pin_oe_n_out;
    logic mgmt_data_pin_in, mgmt_data_pin_out, mgmt_data_pin_oe_n_out;
    logic carrier_sense_out, mgmt_busy_out, mgmt_done_out;
    logic tx = 1'b0, rx = 1'b0, col = 1'b0, carrier_sense_in, p_en, p_d;
    logic [63:0] fr;
    int failures = 0, n_tests = 0;

    always #5 clk_sys_in = ~clk_sys_in;
    always #32 serial_ref_clock_in = ~serial_ref_clock_in;
    assign mgmt_clock_pin_in = mgmt_clock_pin_oe_n_out ? 1'b0 : mgmt_clock_pin_out;
    // the data pin has a pull-up
    assign mgmt_data_pin_in = !mgmt_data_pin_oe_n_out ? mgmt_data_pin_out : (p_en ? p_d : 1'b1);
    assign port_carrier_sense_in = port_carrier_sense_oe_n_out ? carrier_sense_in : port_carrier_sense_out;
    always @(posedge mgmt_clock_pin_in)
        if (mgmt_busy_out)
            fr <= {fr[62:0], mgmt_data_pin_in};

    port_sync_mgmt i_dut (.*);
    phy_model i_phy (.mdc_in(mgmt_clock_pin_in), .mdio_rel_in(mgmt_data_pin_oe_n_out), .tx_busy_in(tx),
        .rx_busy_in(rx), .col_in(col), .crs_out(carrier_sense_in), .mdio_en_out(p_en), .mdio_out(p_d));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("%0d mismatches in %0d comparisons", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic xfer(input row_t w);
        int k;
        @(negedge clk_sys_in);
        {mgmt_read_in, mgmt_phy_addr_in, mgmt_reg_addr_in, mgmt_wdata_in} = w[42:16];
        mgmt_start_in = 1'b1;
        @(negedge clk_sys_in);
        mgmt_start_in = 1'b0;
        for (k = 0; k < 2000 && mgmt_done_out !== 1'b1; k++)
            @(negedge clk_sys_in);
        if (k == 2000)
        begin
            failures++;
            conclude();
        end
    endtask : xfer

    task automatic sync_chk(input port_mode_t m);
        int k;
        int g;
        @(negedge clk_sys_in);
        port_mode_in = m;
        port_enable_in = 1'b1;
        for (k = 0; k < 40 && port_carrier_sense_out !== 1'b1; k++)
            @(negedge serial_ref_clock_in);
        g = 0;
        repeat (30)
        begin
            @(negedge serial_ref_clock_in);
            g += (port_carrier_sense_out === 1'b1);
        end
        chk(g, 3);
        chk({port_carrier_sense_oe_n_out, carrier_sense_out}, 2'h0);
        @(negedge clk_sys_in);
        port_enable_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk(port_carrier_sense_oe_n_out, 1'b1);
    endtask : sync_chk

    initial
    begin
        repeat (20) @(negedge clk_sys_in);
        chk({port_carrier_sense_oe_n_out, mgmt_data_pin_oe_n_out, mgmt_clock_pin_oe_n_out}, 3'h7);
        rst_in = 1'b0;
        @(negedge clk_sys_in);
        // start while disabled must be ignored
        mgmt_start_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        mgmt_start_in = 1'b0;
        chk({mgmt_busy_out, port_carrier_sense_oe_n_out, mgmt_data_pin_oe_n_out, mgmt_clock_pin_oe_n_out}, 4'h7);
        port_enable_in = 1'b1;
        mgmt_clk_drive_in = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            {tx, rx, col} = (i == 3) ? 3'h0 : 3'(1 << i);
            repeat (6) @(negedge clk_sys_in);
            chk(carrier_sense_out, 1'(i != 3));
        end
        foreach (rows[i])
        begin
            xfer(rows[i]);
            chk(fr, {MGMT_PREAMBLE, MGMT_START, rows[i].r ? MGMT_OP_READ : MGMT_OP_WRITE, rows[i].pa, rows[i].ra,
                rows[i].r ? {2'h2, RD} : {MGMT_TA_WRITE, rows[i].wd}});
            chk(mgmt_rdata_out, rows[i].rd);
        end
        port_enable_in = 1'b0;
        sync_chk(MODE_SERIAL);
        sync_chk(MODE_SRC_SYNC);
        conclude();
    end
endmodule : test_mii_serial_segment_sync_and_mgmt_pins
